// >>> include/cut_defs.svh
/*
 * Register map, field positions, reset values and prescaler counts
 * of the capture up/down timer.
 * Assumes a 32-bit byte address compared in full by the register slave.
 */
`ifndef CUT_DEFS_SVH
`define CUT_DEFS_SVH

`define CUT_ADDR_RELOAD     32'hFFFF0380
`define CUT_ADDR_COUNT      32'hFFFF0384
`define CUT_ADDR_CONTROL    32'hFFFF0388
`define CUT_ADDR_INTCLR     32'hFFFF038C
`define CUT_ADDR_CAPTURE    32'hFFFF0390
`define CUT_ADDR_IRQ_STAT   32'hFFFF0394
`define CUT_ADDR_IRQ_MASK   32'hFFFF0398

`define CUT_RST_RELOAD      16'h0000
`define CUT_RST_COUNT       16'hFFFF
`define CUT_RST_CONTROL     32'h00000000
`define CUT_RST_CAPTURE     16'h0000
`define CUT_RST_IRQ_MASK    2'h1

`define CUT_CTRL_WR_MASK    32'h0003F3CF
`define CUT_CAP_EN_BIT      17
`define CUT_SEL_HI          16
`define CUT_SEL_LO          12
`define CUT_CLKSEL_BIT      9
`define CUT_UP_BIT          8
`define CUT_EN_BIT          7
`define CUT_PERIODIC_BIT    6
`define CUT_PRE_HI          3
`define CUT_PRE_LO          0

`define CUT_PRE_DIV1        4'h0
`define CUT_PRE_DIV16       4'h4
`define CUT_PRE_DIV256      4'h8
`define CUT_PRE_DIV32768    4'hF
`define CUT_LIM_DIV1        15'h0000
`define CUT_LIM_DIV16       15'h000F
`define CUT_LIM_DIV256      15'h00FF
`define CUT_LIM_DIV32768    15'h7FFF

`define CUT_NUM_SRC         18
`define CUT_SEL_MAX         5'h11
`define CUT_ST_TIMEOUT      0
`define CUT_ST_CAPTURE      1
`define CUT_CNT_MAX         16'hFFFF
`define CUT_CNT_MIN         16'h0000

`endif

// >>> include/cut_pkg.sv
/*
 * Types of the capture up/down timer: bus request carrier and state record.
 * Assumes cut_defs.svh is on the include path.
 */
`include "cut_defs.svh"

package cut_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cut_bus_req_s;

  typedef struct packed {
    logic [15:0]               reload;
    logic [15:0]               count;
    logic [31:0]               control;
    logic [15:0]               capture;
    logic [1:0]                irq_stat;
    logic [1:0]                irq_mask;
    logic [14:0]               prescale;
    logic [2:0]                lp_sync;
    logic                      lp_level;
    logic [`CUT_NUM_SRC-1:0]   src_prev;
    logic [31:0]               rdata;
    logic                      irq;
    logic                      timeout;
  } cut_state_s;

endpackage

// >>> src/cut_timer.sv
/*
 * Capture up/down timer: 16-bit counter with source select, prescaler,
 * periodic or free-running modes, event capture and a maskable interrupt.
 * Assumes a single-cycle register master on clk, interrupt sources that are
 * synchronous to clk, and a 32.768 kHz oscillator input from its own domain.
 */
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "cut_defs.svh"

module cut_timer (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire cut_pkg::cut_bus_req_s         bus_req,
  output logic [31:0]                        bus_rdata,
  input  wire logic                          lp_osc_clk,
  input  wire logic [`CUT_NUM_SRC-1:0]       irq_sources,
  output logic                               irq,
  output logic [15:0]                        serial_test_interface_count,
  output logic                               serial_test_interface_tick
);
  import cut_pkg::*;

  cut_state_s s_q;
  cut_state_s s_d;

  // Unlisted prescaler codes fall back to divide by one
  function automatic logic [14:0] pre_limit(input logic [3:0] code);
    case (code)
      `CUT_PRE_DIV1:     pre_limit = `CUT_LIM_DIV1;
      `CUT_PRE_DIV16:    pre_limit = `CUT_LIM_DIV16;
      `CUT_PRE_DIV256:   pre_limit = `CUT_LIM_DIV256;
      `CUT_PRE_DIV32768: pre_limit = `CUT_LIM_DIV32768;
      default:           pre_limit = `CUT_LIM_DIV1;
    endcase
  endfunction

  function automatic logic hit(input cut_bus_req_s req, input logic [31:0] addr);
    hit = (req.addr == addr);
  endfunction

  logic                    src_tick;
  logic                    pre_tick;
  logic                    count_up;
  logic                    at_end;
  logic                    cnt_step;
  logic [4:0]              cap_sel;
  logic [`CUT_NUM_SRC-1:0] src_rise;
  logic                    cap_event;
  logic [1:0]              events;
  logic [1:0]              w1c;

  always_comb begin
    s_d = s_q;

    // Oscillator level accepted only once the last two stages agree
    s_d.lp_sync = {s_q.lp_sync[1:0], lp_osc_clk};
    if (s_q.lp_sync[1] == s_q.lp_sync[2]) begin
      s_d.lp_level = s_q.lp_sync[2];
    end

    // Source select
    if (s_q.control[`CUT_CLKSEL_BIT]) begin
      src_tick = s_d.lp_level & ~s_q.lp_level;
    end else begin
      src_tick = 1'b1;
    end

    // Prescaler runs only while counting is enabled
    pre_tick = 1'b0;
    if (!s_q.control[`CUT_EN_BIT]) begin
      s_d.prescale = 15'h0000;
    end else if (src_tick) begin
      if (s_q.prescale >= pre_limit(s_q.control[`CUT_PRE_HI:`CUT_PRE_LO])) begin
        s_d.prescale = 15'h0000;
        pre_tick     = 1'b1;
      end else begin
        s_d.prescale = s_q.prescale + 15'h0001;
      end
    end

    // Counter step, direction and end of count
    count_up = s_q.control[`CUT_UP_BIT];
    at_end   = count_up ? (s_q.count == `CUT_CNT_MAX) : (s_q.count == `CUT_CNT_MIN);
    cnt_step = pre_tick;
    s_d.timeout = 1'b0;
    if (cnt_step) begin
      if (at_end) begin
        s_d.timeout = 1'b1;
        if (s_q.control[`CUT_PERIODIC_BIT]) begin
          s_d.count = s_q.reload;
        end else begin
          s_d.count = count_up ? `CUT_CNT_MIN : `CUT_CNT_MAX;
        end
      end else if (count_up) begin
        s_d.count = s_q.count + 16'h0001;
      end else begin
        s_d.count = s_q.count - 16'h0001;
      end
    end

    // Capture on first assertion of the chosen source; counter untouched
    cap_sel   = s_q.control[`CUT_SEL_HI:`CUT_SEL_LO];
    src_rise  = irq_sources & ~s_q.src_prev;
    s_d.src_prev = irq_sources;
    cap_event = 1'b0;
    if (s_q.control[`CUT_CAP_EN_BIT] && cap_sel <= `CUT_SEL_MAX) begin
      cap_event = src_rise[cap_sel];
    end
    if (cap_event) begin
      s_d.capture = s_q.count;
    end

    // Register writes
    w1c = 2'h0;
    if (bus_req.wr) begin
      if (hit(bus_req, `CUT_ADDR_RELOAD)) begin
        s_d.reload = bus_req.wdata[15:0];
      end
      if (hit(bus_req, `CUT_ADDR_CONTROL)) begin
        s_d.control = bus_req.wdata & `CUT_CTRL_WR_MASK;
      end
      if (hit(bus_req, `CUT_ADDR_INTCLR)) begin
        w1c[`CUT_ST_TIMEOUT] = 1'b1;
      end
      if (hit(bus_req, `CUT_ADDR_IRQ_STAT)) begin
        w1c = w1c | bus_req.wdata[1:0];
      end
      if (hit(bus_req, `CUT_ADDR_IRQ_MASK)) begin
        s_d.irq_mask = bus_req.wdata[1:0];
      end
      // Count and capture addresses fall through unstored
    end

    // Sticky events; a set in the clearing cycle wins
    events = 2'h0;
    events[`CUT_ST_TIMEOUT] = s_d.timeout;
    events[`CUT_ST_CAPTURE] = cap_event;
    s_d.irq_stat = (s_q.irq_stat & ~w1c) | events;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

    // Read data valid only in the cycle after the strobe
    s_d.rdata = 32'h00000000;
    if (bus_req.rd) begin
      if (hit(bus_req, `CUT_ADDR_RELOAD)) begin
        s_d.rdata = {16'h0000, s_q.reload};
      end else if (hit(bus_req, `CUT_ADDR_COUNT)) begin
        s_d.rdata = {16'h0000, s_q.count};
      end else if (hit(bus_req, `CUT_ADDR_CONTROL)) begin
        s_d.rdata = s_q.control;
      end else if (hit(bus_req, `CUT_ADDR_CAPTURE)) begin
        s_d.rdata = {16'h0000, s_q.capture};
      end else if (hit(bus_req, `CUT_ADDR_IRQ_STAT)) begin
        s_d.rdata = {30'h00000000, s_q.irq_stat};
      end else if (hit(bus_req, `CUT_ADDR_IRQ_MASK)) begin
        s_d.rdata = {30'h00000000, s_q.irq_mask};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q.reload   <= `CUT_RST_RELOAD;
      s_q.count    <= `CUT_RST_COUNT;
      s_q.control  <= `CUT_RST_CONTROL;
      s_q.capture  <= `CUT_RST_CAPTURE;
      s_q.irq_stat <= 2'h0;
      s_q.irq_mask <= `CUT_RST_IRQ_MASK;
      s_q.prescale <= 15'h0000;
      s_q.lp_sync  <= 3'h0;
      s_q.lp_level <= 1'b0;
      s_q.src_prev <= '0;
      s_q.rdata    <= 32'h00000000;
      s_q.irq      <= 1'b0;
      s_q.timeout  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata                   = s_q.rdata;
  assign irq                         = s_q.irq;
  // Live count doubles as the test interface time base
  assign serial_test_interface_count = s_q.count;
  assign serial_test_interface_tick  = s_q.timeout;

endmodule

// >>> test/cut_timer_monitor.sv
/* Port checker for the capture up/down timer.
   Assumes a bind onto cut_timer and the single clk domain. */
`timescale 1ns/10ps
`include "cut_defs.svh"
module cut_timer_monitor (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire cut_pkg::cut_bus_req_s bus_req,
  input wire logic [31:0]           bus_rdata,
  input wire logic                  irq,
  input wire logic [15:0]           serial_test_interface_count,
  input wire logic                  serial_test_interface_tick
);
  import cut_pkg::*;
  wire [15:0] cnt = serial_test_interface_count;
  wire        tck = serial_test_interface_tick;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rd(logic [31:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  // Only a still count has a known value at the read
  property p_cnt_read;
    (s_rd(`CUT_ADDR_COUNT) ##0 $stable(cnt)) ##1 $stable(cnt) |-> bus_rdata == {16'h0, cnt};
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read mismatch");
  property p_reload_hi;
    s_rd(`CUT_ADDR_RELOAD) |=> bus_rdata[31:16] == 16'h0;
  endproperty
  a_reload_hi: assert property (p_reload_hi) else $error("reload upper bits set");
  property p_ctrl_rsv;
    s_rd(`CUT_ADDR_CONTROL) |=> (bus_rdata & ~`CUT_CTRL_WR_MASK) == 32'h0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("control reserved bit set");
  property p_idle;
    !bus_req.rd |=> bus_rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_step;
    $changed(cnt) && !tck |-> cnt == $past(cnt) + 16'h1 || cnt == $past(cnt) - 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_tick_end;
    tck |-> $past(cnt) == `CUT_CNT_MIN || $past(cnt) == `CUT_CNT_MAX;
  endproperty
  a_tick_end: assert property (p_tick_end) else $error("timeout off end value");
  property p_tick_irq;
    tck |-> irq;
  endproperty
  a_tick_irq: assert property (p_tick_irq) else $error("timeout without interrupt");
  property p_irq_hold;
    $fell(irq) |-> $past(bus_req.wr);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped unasked");
endmodule

// >>> test/tb_top.sv
/* Self-checking bench of the capture up/down timer.
   Assumes cut_timer_monitor is compiled beside it. */
`timescale 1ns/10ps
`include "cut_defs.svh"
module tb_top;
  import cut_pkg::*;
  logic         clk         = 1'b0;
  logic         resetn      = 1'b0;
  cut_bus_req_s req         = '0;
  logic         lp          = 1'b0;
  logic [17:0]  src         = '0;
  logic [31:0]  rdata;
  logic [31:0]  v;
  logic [15:0]  cnt;
  logic         irq;
  logic         tick;
  int           failures    = 0;
  int           comparisons = 0;
  int           cycles      = 0;
  int           n;
  cut_timer i_dut (.clk(clk), .resetn(resetn), .bus_req(req), .bus_rdata(rdata), .lp_osc_clk(lp),
    .irq_sources(src), .irq(irq), .serial_test_interface_count(cnt), .serial_test_interface_tick(tick));
  initial forever #25 clk = ~clk;
  task automatic give_verdict();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // Bounded so a dead timer shows up as a wrong interval, not a hang
  task automatic wt(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (tick !== 1'b1 && k < 70000);
  endtask
  task automatic t_reset();
    rdc(`CUT_ADDR_RELOAD, 32'h0);
    rdc(`CUT_ADDR_COUNT, 32'hFFFF);
    rdc(`CUT_ADDR_CONTROL, 32'h0);
    rdc(`CUT_ADDR_CAPTURE, 32'h0);
    rdc(`CUT_ADDR_IRQ_MASK, 32'h1);
    rdc(32'hFFFF039C, 32'h0);
    wr(`CUT_ADDR_RELOAD, 32'hABCD);
    rdc(`CUT_ADDR_RELOAD, 32'hABCD);
  endtask
  task automatic t_ro();
    wr(`CUT_ADDR_CONTROL, 32'hFFFFFFFF);
    rdc(`CUT_ADDR_CONTROL, `CUT_CTRL_WR_MASK);
    wr(`CUT_ADDR_CONTROL, 32'h0);
    wr(`CUT_ADDR_COUNT, 32'h1234);
    wr(`CUT_ADDR_CAPTURE, 32'h5678);
    rdc(`CUT_ADDR_COUNT, 32'hFFFF);
    rdc(`CUT_ADDR_CAPTURE, 32'h0);
  endtask
  task automatic t_up();
    wr(`CUT_ADDR_CONTROL, 32'h180);
    wt(n);
    chk(32'(n <= 5), 32'h1);
    chk(irq, 1'b1);
    wr(`CUT_ADDR_CONTROL, 32'h0);
    wr(`CUT_ADDR_INTCLR, 32'hA5);
    chk(irq, 1'b0);
    rd(`CUT_ADDR_COUNT, v);
    rdc(`CUT_ADDR_COUNT, v);
  endtask
  task automatic t_period();
    logic [3:0] code [4] = '{4'h0, 4'h4, 4'h8, 4'hF};
    int         rl   [4] = '{5, 5, 0, 0};
    int         per  [4] = '{6, 96, 256, 32768};
    for (int i = 0; i < 4; i++) begin
      wr(`CUT_ADDR_RELOAD, 32'(rl[i]));
      wr(`CUT_ADDR_CONTROL, {24'h0, 4'hC, code[i]});
      wt(n);
      wt(n);
      chk(32'(n), 32'(per[i]));
    end
  endtask
  task automatic t_lp();
    wr(`CUT_ADDR_CONTROL, 32'h0);
    wr(`CUT_ADDR_CONTROL, 32'h280);
    rd(`CUT_ADDR_COUNT, v);
    repeat (3) begin
      repeat (8) @(posedge clk);
      lp <= 1'b1;
      repeat (8) @(posedge clk);
      lp <= 1'b0;
    end
    repeat (10) @(posedge clk);
    rdc(`CUT_ADDR_COUNT, {16'h0, v[15:0] - 16'h3});
  endtask
  task automatic t_cap();
    wr(`CUT_ADDR_CONTROL, 32'h31000);
    wr(`CUT_ADDR_INTCLR, 32'h0);
    chk(irq, 1'b0);
    rd(`CUT_ADDR_COUNT, v);
    @(posedge clk);
    src <= 18'h10000;
    rdc(`CUT_ADDR_CAPTURE, 32'h0);
    @(posedge clk);
    src <= 18'h30000;
    repeat (2) @(posedge clk);
    rdc(`CUT_ADDR_CAPTURE, v);
    chk(irq, 1'b0);
    wr(`CUT_ADDR_IRQ_MASK, 32'h3);
    chk(irq, 1'b1);
    wr(`CUT_ADDR_IRQ_STAT, 32'h2);
    chk(irq, 1'b0);
    @(posedge clk);
    src <= 18'h0;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_ro();
    t_up();
    t_period();
    t_lp();
    t_cap();
    give_verdict();
  end
endmodule
bind cut_timer cut_timer_monitor i_mon (.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .irq(irq), .serial_test_interface_count(serial_test_interface_count),
  .serial_test_interface_tick(serial_test_interface_tick));
